// ===== rtl/scc_pkg.sv
// Constants for the system clock control block.
package scc_pkg;
	// Register index as printed; the byte address is four times it.
	localparam logic [7:0] SCC_CTRL_IDX = 8'h0e;
	localparam logic [7:0] SCC_CTRL_ADDR = 8'h38;
	localparam logic [7:0] SCC_OSC_ADDR = 8'h3c;
	localparam logic [7:0] SCC_STAT_ADDR = 8'h40;
	// Control register fields.
	localparam int SCC_XT_BIT = 7;
	localparam int SCC_RSV_BIT = 6;
	localparam int SCC_RC_BIT = 5;
	localparam int SCC_STOP_BIT = 4;
	localparam int SCC_SWB_BIT = 3;
	localparam int SCC_POWER_MANAGE_ENABLE_BIT = 2;
	localparam int SCC_CD_HI = 1;
	localparam int SCC_CD_LO = 0;
	localparam logic [4:0] SCC_LOW_RESET = 5'h01;
	localparam logic [1:0] SCC_CD_DIV1 = 2'h0;
	// Oscillator register fields and power-on values.
	localparam int SCC_XON_BIT = 0;
	localparam int SCC_RCE_BIT = 1;
	localparam logic SCC_XON_RESET = 1'b0;
	localparam logic SCC_RCE_RESET = 1'b1;
	// Status register fields.
	localparam int SCC_RDY_BIT = 0;
	localparam int SCC_FAIL_BIT = 1;
	// Divider limits, one less than oscillator cycles per system clock.
	localparam logic [7:0] SCC_PM_LIMIT = 8'hff;
	localparam logic [7:0] SCC_BASE_LIMIT = 8'h01;
	// Bus responses.
	localparam logic [1:0] SCC_RESP_OKAY = 2'h0;
	localparam logic [1:0] SCC_RESP_SLVERR = 2'h2;
endpackage

// ===== rtl/scc_top.sv
// System clock control register, source swap, divider, stop and switchback.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module scc_top #(
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic por_n,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic crystal_warm,
	input wire logic ext_int_event,
	input wire logic ext_int_enable,
	input wire logic uart_rx,
	input wire logic [1:0] uart_mode,
	input wire logic uart_rx_enable,
	input wire logic uart_tx_buffer_wr,
	input wire logic uart_tx_enable,
	input wire logic spi_data_buffer_wr,
	input wire logic spi_master_indicator,
	input wire logic spi_tx_enable,
	input wire logic spi_slave_select_n,
	input wire logic can_rx_input,
	input wire logic can_int_enable,
	input wire logic debug_entry,
	output logic sys_clk_pulse,
	output logic crystal_source,
	output logic stop_mode,
	output logic rc_osc_run,
	output logic crystal_osc_run
);

	// Divider limit from the control fields.
	function automatic logic [7:0] div_limit(input logic pm, input logic [1:0] cd);
		logic [7:0] lim;
		lim = 8'h00;
		if (pm)
		begin
			lim = scc_pkg::SCC_PM_LIMIT;
		end
		else
		begin
			unique case (cd)
				2'h0: lim = 8'h00;
				2'h1: lim = scc_pkg::SCC_BASE_LIMIT;
				2'h2: lim = 8'h03;
				2'h3: lim = 8'h07;
			endcase
		end
		return lim;
	endfunction

	logic rst;
	logic por;
	logic xt_r;
	logic src_xtal_r;
	logic stop_r;
	logic swb_r;
	logic power_manage_enable_r;
	logic [1:0] cd_r;
	logic xon_r;
	logic rce_r;
	logic fail_r;
	logic sb_hold_r;
	logic uart_rx_r;
	logic can_rx_r;
	logic [7:0] cnt_r;
	logic [7:0] lim_r;
	logic pulse_r;
	logic aw_hold_r;
	logic w_hold_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;
	logic wr_fire;
	logic wr_ctrl;
	logic wr_osc;
	logic wr_stat;
	logic wr_map;
	logic rd_fire;
	logic crystal_ready;
	logic tick;
	logic wake;
	logic sb_event;
	logic sb_active;
	logic sb_take;
	logic xtal_fail;
	logic [7:0] ctrl_view;

	// Power-on reset also acts as an ordinary reset.
	assign por = !por_n;
	assign rst = !aresetn || por;

	// The crystal counts as ready only while it is enabled and warm.
	assign crystal_ready = xon_r && crystal_warm;

	// One divider boundary; select-driven swaps and ratio loads happen only here.
	assign tick = (cnt_r == lim_r);

	// Enabled external interrupt both wakes from stop and triggers switchback.
	assign wake = ext_int_event && ext_int_enable;

	// Edge and write style sources that fire once.
	assign sb_event = wake
		|| (uart_rx_r && !uart_rx && uart_mode != 2'h0 && uart_rx_enable)
		|| (uart_tx_buffer_wr && uart_tx_enable)
		|| (spi_data_buffer_wr && spi_master_indicator && spi_tx_enable)
		|| (can_rx_r != can_rx_input && can_int_enable)
		|| debug_entry;

	// Level source plus the one-shot sources of this cycle.
	assign sb_active = sb_event || (!spi_master_indicator && !spi_slave_select_n);

	// Switchback only acts when both enables are set.
	assign sb_take = swb_r && power_manage_enable_r && sb_active;

	// Loss of a crystal that was running as the system clock.
	// Stop halts the crystal on purpose, so that loss must not count as a failure.
	assign xtal_fail = src_xtal_r && !crystal_ready && !stop_r;

	// Register view; bit 6 is constant zero and bit 5 is the inverse of the source.
	assign ctrl_view = {xt_r, 1'b0, !src_xtal_r, stop_r, swb_r, power_manage_enable_r, cd_r};

	// Bus write commits once address and data are both held.
	assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
	assign wr_ctrl = wr_fire && awaddr_r[7:0] == scc_pkg::SCC_CTRL_ADDR && wstrb_r[0];
	assign wr_osc = wr_fire && awaddr_r[7:0] == scc_pkg::SCC_OSC_ADDR && wstrb_r[0];
	assign wr_stat = wr_fire && awaddr_r[7:0] == scc_pkg::SCC_STAT_ADDR && wstrb_r[0];
	assign wr_map = awaddr_r[7:0] == scc_pkg::SCC_CTRL_ADDR
		|| awaddr_r[7:0] == scc_pkg::SCC_OSC_ADDR
		|| awaddr_r[7:0] == scc_pkg::SCC_STAT_ADDR;
	assign rd_fire = s_axi_arvalid && !rvalid_r;

	// Handshake outputs come straight from hold state.
	assign s_axi_awready = !aw_hold_r && !bvalid_r;
	assign s_axi_wready = !w_hold_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

	// Outputs toward the clock tree and oscillators.
	assign sys_clk_pulse = pulse_r;
	assign crystal_source = src_xtal_r;
	assign stop_mode = stop_r;
	assign rc_osc_run = rce_r && !stop_r;
	assign crystal_osc_run = xon_r && !stop_r;

	// Write address and data are captured independently, in either order.
	always_ff @(posedge aclk)
	begin
		if (rst)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end
		else if (wr_fire)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
		end
	end

	// Write response; unmapped addresses answer with a slave error.
	always_ff @(posedge aclk)
	begin
		if (rst)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= scc_pkg::SCC_RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_map ? scc_pkg::SCC_RESP_OKAY : scc_pkg::SCC_RESP_SLVERR;
		end
		else if (s_axi_bready)
		begin
			bvalid_r <= 1'b0;
		end
	end

	// Read path; data is latched at the address handshake.
	always_ff @(posedge aclk)
	begin
		if (rst)
		begin
			rvalid_r <= 1'b0;
			rresp_r <= scc_pkg::SCC_RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end
		else if (rd_fire)
		begin
			rvalid_r <= 1'b1;
			rresp_r <= scc_pkg::SCC_RESP_OKAY;
			rdata_r <= 32'h0000_0000;
			unique case (s_axi_araddr[7:0])
				scc_pkg::SCC_CTRL_ADDR: rdata_r[7:0] <= ctrl_view;
				scc_pkg::SCC_OSC_ADDR: rdata_r[1:0] <= {rce_r, xon_r};
				scc_pkg::SCC_STAT_ADDR: rdata_r[1:0] <= {fail_r, crystal_ready};
				default: rresp_r <= scc_pkg::SCC_RESP_SLVERR;
			endcase
		end
		else if (s_axi_rready)
		begin
			rvalid_r <= 1'b0;
		end
	end

	// Crystal select survives every reset except power-on.
	always_ff @(posedge aclk)
	begin
		if (por)
		begin
			xt_r <= 1'b0;
		end
		else if (xtal_fail)
		begin
			xt_r <= 1'b0;
		end
		else if (wr_ctrl && !wdata_r[scc_pkg::SCC_STOP_BIT])
		begin
			xt_r <= wdata_r[scc_pkg::SCC_XT_BIT];
		end
	end

	// Source follows the select at a boundary, gated by crystal readiness toward the crystal and by the RC enable toward RC.
	always_ff @(posedge aclk)
	begin
		if (por)
		begin
			src_xtal_r <= 1'b0;
		end
		else if (xtal_fail)
		begin
			src_xtal_r <= 1'b0;
		end
		else if (stop_r)
		begin
			// Resume runs from the RC oscillator while the crystal warms again.
			src_xtal_r <= 1'b0;
		end
		else if (tick && !stop_r)
		begin
			if (xt_r && crystal_ready)
			begin
				src_xtal_r <= 1'b1;
			end
			else if (!xt_r && rce_r)
			begin
				src_xtal_r <= 1'b0;
			end
		end
	end

	// Oscillator enables keep their values except on power-on reset.
	always_ff @(posedge aclk)
	begin
		if (por)
		begin
			xon_r <= scc_pkg::SCC_XON_RESET;
			rce_r <= scc_pkg::SCC_RCE_RESET;
		end
		else
		begin
			if (wr_osc)
			begin
				xon_r <= wdata_r[scc_pkg::SCC_XON_BIT];
				rce_r <= wdata_r[scc_pkg::SCC_RCE_BIT];
			end
			if (xtal_fail)
			begin
				rce_r <= 1'b1;
			end
		end
	end

	// Failure flag is sticky; a new failure wins over a same-cycle clear.
	always_ff @(posedge aclk)
	begin
		if (por)
		begin
			fail_r <= 1'b0;
		end
		else if (xtal_fail)
		begin
			fail_r <= 1'b1;
		end
		else if (wr_stat && wdata_r[scc_pkg::SCC_FAIL_BIT])
		begin
			fail_r <= 1'b0;
		end
	end

	// Low five control bits; switchback outranks a software write.
	always_ff @(posedge aclk)
	begin
		if (rst)
		begin
			{stop_r, swb_r, power_manage_enable_r, cd_r} <= scc_pkg::SCC_LOW_RESET;
		end
		else
		begin
			if (wake)
			begin
				stop_r <= 1'b0;
			end
			else if (wr_ctrl && wdata_r[scc_pkg::SCC_STOP_BIT])
			begin
				stop_r <= 1'b1;
			end
			if (sb_take)
			begin
				power_manage_enable_r <= 1'b0;
				cd_r <= scc_pkg::SCC_CD_DIV1;
			end
			else if (wr_ctrl && !wdata_r[scc_pkg::SCC_STOP_BIT])
			begin
				// A stop write leaves these fields as they are.
				swb_r <= wdata_r[scc_pkg::SCC_SWB_BIT];
				cd_r <= wdata_r[scc_pkg::SCC_CD_HI:scc_pkg::SCC_CD_LO];
				if (!(wdata_r[scc_pkg::SCC_POWER_MANAGE_ENABLE_BIT] && sb_hold_r && sb_active))
				begin
					power_manage_enable_r <= wdata_r[scc_pkg::SCC_POWER_MANAGE_ENABLE_BIT];
				end
			end
		end
	end

	// Remember a switchback until its sources have gone quiet.
	always_ff @(posedge aclk)
	begin
		if (rst)
		begin
			sb_hold_r <= 1'b0;
		end
		else if (sb_take)
		begin
			sb_hold_r <= 1'b1;
		end
		else if (!sb_active)
		begin
			sb_hold_r <= 1'b0;
		end
	end

	// Previous levels for edge detection on receive lines.
	always_ff @(posedge aclk)
	begin
		if (rst)
		begin
			uart_rx_r <= 1'b1;
			can_rx_r <= 1'b1;
		end
		else
		begin
			uart_rx_r <= uart_rx;
			can_rx_r <= can_rx_input;
		end
	end

	// Divider; a new ratio is picked up only at a boundary so no pulse is cut.
	always_ff @(posedge aclk)
	begin
		if (rst)
		begin
			cnt_r <= 8'h00;
			lim_r <= scc_pkg::SCC_BASE_LIMIT;
			pulse_r <= 1'b0;
		end
		else if (stop_r)
		begin
			cnt_r <= 8'h00;
			pulse_r <= 1'b0;
		end
		else if (tick)
		begin
			cnt_r <= 8'h00;
			lim_r <= div_limit(power_manage_enable_r, cd_r);
			pulse_r <= 1'b1;
		end
		else
		begin
			cnt_r <= cnt_r + 8'h01;
			pulse_r <= 1'b0;
		end
	end

endmodule // scc_top

// ===== testbench/scc_osc_model.sv
// Crystal oscillator model with warm-up and a commanded failure.
`timescale 1ns/1ps
module scc_osc_model #(
	parameter int WARM = 40
) (
	input wire logic aclk,
	input wire logic crystal_osc_run,
	input wire logic fail_cmd,
	output logic crystal_warm
);
	logic [7:0] warm_cnt_r;
	// A stopped or failing crystal loses its warm-up and must start over.
	always_ff @(posedge aclk)
	begin
		if (!crystal_osc_run || fail_cmd)
			warm_cnt_r <= 8'h00;
		else if (warm_cnt_r != 8'(WARM))
			warm_cnt_r <= warm_cnt_r + 8'h01;
	end
	assign crystal_warm = (warm_cnt_r == 8'(WARM));
endmodule // scc_osc_model

// ===== testbench/scc_checker.sv
// Assertion checker for the system clock control block.
`timescale 1ns/1ps
module scc_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic por_n,
	input wire logic s_axi_bvalid,
	input wire logic crystal_warm,
	input wire logic ext_int_event,
	input wire logic ext_int_enable,
	input wire logic sys_clk_pulse,
	input wire logic crystal_source,
	input wire logic stop_mode,
	input wire logic rc_osc_run,
	input wire logic crystal_osc_run
);
	// Ordinary reset is handled inside the properties that care about it.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!por_n);
	// Stop and wake.
	property p_stop_quiet;
		stop_mode |-> !sys_clk_pulse && !rc_osc_run && !crystal_osc_run;
	endproperty
	a_stop_quiet: assert property (p_stop_quiet)
		else $error("clock running in stop");
	property p_stop_set;
		$rose(stop_mode) |-> $rose(s_axi_bvalid);
	endproperty
	a_stop_set: assert property (p_stop_set)
		else $error("stop entered without a write");
	property p_stop_wake;
		stop_mode && ext_int_event && ext_int_enable |=> !stop_mode;
	endproperty
	a_stop_wake: assert property (p_stop_wake)
		else $error("enabled interrupt did not end stop");
	property p_stop_hold;
		stop_mode && aresetn && !(ext_int_event && ext_int_enable) |=> stop_mode;
	endproperty
	a_stop_hold: assert property (p_stop_hold)
		else $error("stop ended without cause");
	property p_rst_stop;
		!aresetn |=> !stop_mode;
	endproperty
	a_rst_stop: assert property (p_rst_stop)
		else $error("reset left stop set");
	// Source selection.
	property p_por_rc;
		$rose(por_n) |-> !crystal_source && rc_osc_run && !crystal_osc_run;
	endproperty
	a_por_rc: assert property (p_por_rc)
		else $error("power-on did not select the RC source");
	property p_fail;
		crystal_source && !crystal_warm |=> !crystal_source && (rc_osc_run || stop_mode);
	endproperty
	a_fail: assert property (p_fail)
		else $error("failed crystal kept as source");
	property p_unready;
		!crystal_source && !crystal_warm |=> !crystal_source;
	endproperty
	a_unready: assert property (p_unready)
		else $error("swap to an unready crystal");
	c_stop: cover property ($rose(stop_mode));
	c_xtal: cover property ($rose(crystal_source));
	c_back: cover property ($fell(crystal_source));
endmodule // scc_checker
bind scc_top scc_checker i_chk (.*);

// ===== testbench/test_system_clock_control.sv
// Self-checking testbench for the system clock control block.
`timescale 1ns/1ps
module test_system_clock_control;
	logic aclk, aresetn, por_n, fail_cmd;
	logic [7:0] s_axi_awaddr, s_axi_araddr, d;
	logic [31:0] s_axi_wdata, s_axi_rdata, q;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, uart_mode, rs, bs;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, crystal_warm;
	logic ext_int_event, ext_int_enable, uart_rx, uart_rx_enable, uart_tx_buffer_wr;
	logic uart_tx_enable, spi_data_buffer_wr, spi_master_indicator, spi_tx_enable;
	logic spi_slave_select_n, can_rx_input, can_int_enable, debug_entry, sys_clk_pulse;
	logic crystal_source, stop_mode, rc_osc_run, crystal_osc_run;
	int err_total, checks_done, seed, i;
	scc_top i_dut (.*);
	scc_osc_model #(.WARM(40)) i_osc (.aclk, .crystal_osc_run, .fail_cmd, .crystal_warm);
	// Clock at 20 MHz.
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	task tally_and_finish;
		if (err_total == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task tmo;
		err_total++;
		$display("Error wait expected answer seen none");
		tally_and_finish();
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	function automatic int ratio(input logic pm, input logic [1:0] cd);
		return pm ? 256 : (1 << cd);
	endfunction
	// Bus tasks sample ready at the falling edge, which equals its value at the next rise.
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		int n;
		logic aw, w, b;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, v};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		b = 1'b0;
		for (n = 0; n < 50 && !b; n++)
		begin
			@(negedge aclk);
			aw = s_axi_awready;
			w = s_axi_wready;
			b = s_axi_bvalid;
			bs = s_axi_bresp;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) s_axi_bready <= 1'b0;
		end
		if (!b) tmo();
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		logic t, r;
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		r = 1'b0;
		for (n = 0; n < 50 && !r; n++)
		begin
			@(negedge aclk);
			t = s_axi_arready;
			r = s_axi_rvalid;
			q = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge aclk);
			if (t) s_axi_arvalid <= 1'b0;
			if (r) s_axi_rready <= 1'b0;
		end
		if (!r) tmo();
	endtask
	// Measures the gap between the second and third system clock pulses.
	task automatic per(input int e);
		int n, g, c;
		g = 0;
		c = 0;
		for (n = 0; n < 1000 && g < 3; n++)
		begin
			@(negedge aclk);
			if (g == 2) c++;
			if (sys_clk_pulse) g++;
		end
		@(posedge aclk);
		if (g < 3) tmo();
		chk("ratio", e, c);
	endtask
	task automatic wsrc(input logic v);
		int n;
		for (n = 0; n < 400 && crystal_source !== v; n++) @(negedge aclk);
		@(posedge aclk);
		if (n == 400) tmo();
		chk("source", v, crystal_source);
	endtask
	task rst;
		aresetn <= 1'b0;
		@(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask
	// Pulses one switchback source for a cycle; slave select only counts in slave mode.
	// The CAN line idles high, so a pulse is a dip and its return is a second edge.
	task automatic kick(input int k);
		spi_master_indicator <= (k != 4);
		uart_mode <= 2'({$random(seed)} % 3 + 1);
		case (k)
			0: ext_int_event <= 1'b1;
			1: uart_rx <= 1'b0;
			2: uart_tx_buffer_wr <= 1'b1;
			3: spi_data_buffer_wr <= 1'b1;
			4: spi_slave_select_n <= 1'b0;
			5: can_rx_input <= 1'b0;
			default: debug_entry <= 1'b1;
		endcase
		@(posedge aclk);
		{ext_int_event, uart_tx_buffer_wr, spi_data_buffer_wr, debug_entry} <= 4'h0;
		{uart_rx, spi_slave_select_n, can_rx_input} <= 3'h7;
	endtask
	// Main sequence; the wait after reset keeps the first request off the release edge.
	initial
	begin
		seed = 54;
		err_total = 0;
		checks_done = 0;
		{aresetn, por_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 6'h00;
		{s_axi_rready, ext_int_event, uart_tx_buffer_wr, spi_data_buffer_wr} = 4'h0;
		{can_rx_input, debug_entry, fail_cmd} = 3'h4;
		{ext_int_enable, uart_rx, uart_rx_enable, uart_tx_enable, spi_tx_enable} = 5'h1f;
		{can_int_enable, spi_master_indicator, spi_slave_select_n} = 3'h7;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hf;
		uart_mode = 2'h1;
		repeat (5) @(posedge aclk);
		{aresetn, por_n} <= 2'h3;
		@(posedge aclk);
		rd(8'h38);
		chk("ctrl", 32'h21, q);
		rd(8'h44);
		chk("resp", 32'h2, rs);
		wr(8'h44, 8'h00);
		chk("bresp", 32'h2, bs);
		per(2);
		for (i = 0; i < 4; i++)
		begin
			d = (8'($random(seed)) & 8'h60) | 8'(i);
			wr(8'h38, d);
			chk("bresp", 32'h0, bs);
			per(ratio(1'b0, 2'(i)));
			rd(8'h38);
			chk("ctrl", 32'h20 | i, q);
		end
		wr(8'h38, 8'h00);
		wr(8'h38, 8'h04);
		per(ratio(1'b1, 2'h0));
		kick(0);
		rd(8'h38);
		chk("ctrl", 32'h24, q);
		for (i = 0; i < 7; i++)
		begin
			wr(8'h38, 8'h0c);
			kick(i);
			rd(8'h38);
			chk("ctrl", 32'h28, q);
		end
		per(ratio(1'b0, 2'h0));
		{spi_master_indicator, spi_slave_select_n} <= 2'h0;
		wr(8'h38, 8'h0c);
		rd(8'h38);
		chk("ctrl", 32'h28, q);
		wr(8'h38, 8'h04);
		rd(8'h38);
		chk("ctrl", 32'h20, q);
		spi_slave_select_n <= 1'b1;
		@(posedge aclk);
		wr(8'h38, 8'h0c);
		rd(8'h38);
		chk("ctrl", 32'h2c, q);
		wr(8'h38, 8'h01);
		// Stop ignores a masked interrupt and ends on an enabled one.
		wr(8'h38, 8'h13);
		chk("stop", 32'h1, stop_mode);
		chk("rc_run", 32'h0, rc_osc_run);
		{ext_int_enable, ext_int_event} <= 2'h1;
		@(posedge aclk);
		{ext_int_enable, ext_int_event} <= 2'h2;
		repeat (3) @(posedge aclk);
		chk("stop", 32'h1, stop_mode);
		ext_int_event <= 1'b1;
		@(posedge aclk);
		ext_int_event <= 1'b0;
		@(posedge aclk);
		chk("stop", 32'h0, stop_mode);
		chk("rc_run", 32'h1, rc_osc_run);
		rd(8'h38);
		chk("ctrl", 32'h21, q);
		wr(8'h38, 8'h13);
		rst();
		chk("stop", 32'h0, stop_mode);
		// Crystal selected before warm-up, then kept across ordinary reset.
		wr(8'h3c, 8'h03);
		chk("xtal_run", 32'h1, crystal_osc_run);
		wr(8'h38, 8'h81);
		rd(8'h38);
		chk("ctrl", 32'ha1, q);
		wsrc(1'b1);
		rst();
		rd(8'h38);
		chk("ctrl", 32'h81, q);
		repeat (4) @(posedge aclk);
		wr(8'h38, 8'h01);
		wsrc(1'b0);
		// Crystal failure with the RC oscillator switched off.
		wr(8'h38, 8'h81);
		wsrc(1'b1);
		// Stop with the crystal as source resumes on RC while it warms again.
		wr(8'h38, 8'h91);
		repeat (3) @(posedge aclk);
		ext_int_event <= 1'b1;
		@(posedge aclk);
		ext_int_event <= 1'b0;
		rd(8'h38);
		chk("ctrl", 32'ha1, q);
		wsrc(1'b1);
		rd(8'h40);
		chk("fail", 32'h0, q & 32'h2);
		wr(8'h3c, 8'h01);
		fail_cmd <= 1'b1;
		wsrc(1'b0);
		fail_cmd <= 1'b0;
		rd(8'h40);
		chk("fail", 32'h2, q & 32'h2);
		rd(8'h3c);
		chk("rc_en", 32'h2, q & 32'h2);
		rd(8'h38);
		chk("ctrl", 32'h21, q);
		tally_and_finish();
	end
endmodule // test_system_clock_control
